// file: design/ifc_top.sv
// Purpose: Interrupt flags, enables, vectoring and sleep wake-up of a small core.
// Assumes: Sequencer pulses cycle_done at the end of each instruction.
// Notes:   Flags are sampled once per instruction cycle by a four-clock divider.
`timescale 1ns/100ps

module ifc_top
  import ifc_pkg::*;
(
  // Clock and reset
  input  wire logic              CORE_CLK_IN,
  input  wire logic              RST_N_IN,
  // APB slave
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [7:0]        PADDR_IN,
  input  wire logic [31:0]       PWDATA_IN,
  output logic      [31:0]       PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  // Event sources
  input  wire ifc_events_t       EVENTS_IN,
  // Instruction sequencer
  input  wire ifc_seq_t          SEQ_IN,
  output logic                   IRQ_REQ_OUT,
  output logic                   VECTOR_LOAD_OUT,
  output logic      [12:0]       VECTOR_ADDR_OUT,
  output logic                   PUSH_OUT,
  output logic      [12:0]       PUSH_ADDR_OUT,
  output logic                   WAKE_OUT,
  output logic                   ASLEEP_OUT,
  output logic                   IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and wires.

  logic [7:0]  ctrl_r;
  logic [7:0]  option_r;
  logic [7:0]  xflag_r;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  xflag_nxt;
  logic        pin_d_r;
  logic [3:0]  port_d_r;
  logic [1:0]  div_r;
  ifc_state_t  state_r;
  ifc_state_t  state_nxt;
  logic        slot_pend_r;

  wire         wr_en      = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire         rd_setup   = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  wire         hit_ctrl   = PADDR_IN == IFC_OFS_CTRL;
  wire         hit_option = PADDR_IN == IFC_OFS_OPTION;
  wire         hit_xflag  = PADDR_IN == IFC_OFS_XFLAG;
  wire         hit_state  = PADDR_IN == IFC_OFS_STATE;
  wire         unmapped   = ~(hit_ctrl | hit_option | hit_xflag | hit_state);
  wire         wr_ctrl    = wr_en & hit_ctrl;
  wire         wr_xflag   = wr_en & hit_xflag;
  wire         asleep     = state_r == IFC_SLEEP;
  wire         tick       = div_r == 2'(IFC_CYC_DIV - 1);

  wire         pin_rise   = EVENTS_IN.pin & ~pin_d_r;
  wire         pin_fall   = ~EVENTS_IN.pin & pin_d_r;
  wire         pin_edge   = option_r[IFC_B_EDGE] ? pin_rise : pin_fall;
  wire         port_chg   = |(EVENTS_IN.port_hi ^ port_d_r);
  wire         tmr_set    = EVENTS_IN.timer_wrap & ~asleep;

  wire         en_pin     = ctrl_r[IFC_B_PF] & ctrl_r[IFC_B_PIE];
  wire         en_tmr     = ctrl_r[IFC_B_TF] & ctrl_r[IFC_B_TIE];
  wire         en_chg     = ctrl_r[IFC_B_CF] & ctrl_r[IFC_B_CIE];
  wire         en_wr      = xflag_r[IFC_B_WF] & xflag_r[IFC_B_WIE];
  wire         any_en     = en_pin | en_tmr | en_chg | en_wr;
  wire         take       = ctrl_r[IFC_B_GIE] & any_en;
  wire         wake       = asleep & (en_pin | en_chg | en_wr);

  wire [31:0]  rd_mux     = hit_ctrl   ? {24'h000000, ctrl_r}   :
                            hit_option ? {24'h000000, option_r} :
                            hit_xflag  ? {24'h000000, xflag_r}  :
                            hit_state  ? {30'h00000000, state_r} :
                            32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Flag and enable next values; an event wins over a software clear.

  always_comb
  begin
    ctrl_nxt = wr_ctrl ? PWDATA_IN[7:0] : ctrl_r;
    if (pin_edge)
    begin
      ctrl_nxt[IFC_B_PF] = 1'b1;
    end
    if (tmr_set)
    begin
      ctrl_nxt[IFC_B_TF] = 1'b1;
    end
    if (port_chg)
    begin
      ctrl_nxt[IFC_B_CF] = 1'b1;
    end
    if (SEQ_IN.return_from_irq_instr)
    begin
      ctrl_nxt[IFC_B_GIE] = 1'b1;
    end
    if (state_r == IFC_ENTRY)
    begin
      ctrl_nxt[IFC_B_GIE] = 1'b0;
    end
    xflag_nxt = wr_xflag ? {6'h00, PWDATA_IN[1:0]} : xflag_r;
    if (EVENTS_IN.write_done)
    begin
      xflag_nxt[IFC_B_WF] = 1'b1;
    end
  end

  // Entry only at an instruction boundary, so a two-cycle instruction waits.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      IFC_RUN:
      begin
        if (SEQ_IN.cycle_done & slot_pend_r)
        begin
          state_nxt = IFC_ENTRY;
        end
        else if (SEQ_IN.sleep & ~any_en)
        begin
          state_nxt = IFC_SLEEP;
        end
      end
      IFC_ENTRY: state_nxt = IFC_RUN;
      IFC_SLEEP:
      begin
        if (wake)
        begin
          state_nxt = IFC_RUN;
        end
      end
      default: state_nxt = IFC_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clocked state.

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_r   <= IFC_CTRL_RST;
      option_r <= IFC_OPTION_RST;
      xflag_r  <= IFC_XFLAG_RST;
      state_r  <= IFC_RUN;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      option_r <= (wr_en & hit_option) ? PWDATA_IN[7:0] : option_r;
      xflag_r  <= xflag_nxt;
      state_r  <= state_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      // The pins are tracked through reset, so no false edge follows it.
      pin_d_r     <= EVENTS_IN.pin;
      port_d_r    <= EVENTS_IN.port_hi;
      div_r       <= 2'b00;
      slot_pend_r <= 1'b0;
    end
    else
    begin
      pin_d_r     <= EVENTS_IN.pin;
      port_d_r    <= EVENTS_IN.port_hi;
      div_r       <= asleep ? 2'b00 : div_r + 2'b01;
      slot_pend_r <= tick ? take : (slot_pend_r & take);
    end
  end

  // Sequencer and bus outputs, all registered.
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      IRQ_REQ_OUT     <= 1'b0;
      VECTOR_LOAD_OUT <= 1'b0;
      VECTOR_ADDR_OUT <= IFC_VECTOR;
      PUSH_OUT        <= 1'b0;
      PUSH_ADDR_OUT   <= 13'h0000;
      WAKE_OUT        <= 1'b0;
      ASLEEP_OUT      <= 1'b0;
      IRQ_OUT         <= 1'b0;
      PRDATA_OUT      <= 32'h00000000;
      PREADY_OUT      <= 1'b0;
      PSLVERR_OUT     <= 1'b0;
    end
    else
    begin
      IRQ_REQ_OUT     <= slot_pend_r;
      VECTOR_LOAD_OUT <= state_nxt == IFC_ENTRY;
      VECTOR_ADDR_OUT <= IFC_VECTOR;
      PUSH_OUT        <= state_nxt == IFC_ENTRY;
      PUSH_ADDR_OUT   <= SEQ_IN.pc;
      WAKE_OUT        <= wake;
      ASLEEP_OUT      <= state_nxt == IFC_SLEEP;
      IRQ_OUT         <= take;
      // Read data is launched at the setup edge so that it stands with PREADY.
      PRDATA_OUT      <= rd_setup ? rd_mux : 32'h00000000;
      PREADY_OUT      <= PSEL_IN & ~PENABLE_IN;
      PSLVERR_OUT     <= PSEL_IN & ~PENABLE_IN & unmapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_entry;
    state_r == IFC_ENTRY;
  endsequence

  sequence s_sleep_req;
    state_r == IFC_RUN && SEQ_IN.sleep && !any_en
      && !(SEQ_IN.cycle_done && slot_pend_r);
  endsequence

  a_gie_reset: assert property ($rose(RST_N_IN) |-> !ctrl_r[IFC_B_GIE])
    else $error("global enable not clear after reset");
  a_no_take_off: assert property (!ctrl_r[IFC_B_GIE] && state_r == IFC_RUN
      && !slot_pend_r |=> state_r != IFC_ENTRY)
    else $error("entry with global enable clear");
  a_entry_clears: assert property (s_entry |=> !ctrl_r[IFC_B_GIE])
    else $error("entry did not clear global enable");
  a_vector_push: assert property (s_entry |-> VECTOR_LOAD_OUT && PUSH_OUT
      && VECTOR_ADDR_OUT == IFC_VECTOR)
    else $error("vector or push missing at entry");
  a_return_from_irq_instr_sets: assert property (SEQ_IN.return_from_irq_instr && state_r != IFC_ENTRY
      |=> ctrl_r[IFC_B_GIE])
    else $error("return did not set global enable");
  a_flag_sticky: assert property (ctrl_r[IFC_B_PF] && !wr_ctrl
      |=> ctrl_r[IFC_B_PF])
    else $error("pin flag cleared itself");
  a_pin_edge: assert property (pin_edge |=> ctrl_r[IFC_B_PF])
    else $error("edge did not set pin flag");
  a_port_flag: assert property (port_chg |=> ctrl_r[IFC_B_CF])
    else $error("port change did not set flag");
  a_timer_sleep: assert property (asleep && !wr_ctrl && !ctrl_r[IFC_B_TF]
      |=> !ctrl_r[IFC_B_TF])
    else $error("timer flag set while asleep");
  a_wake_exit: assert property (wake |=> !asleep ##0 WAKE_OUT)
    else $error("enabled interrupt did not wake core");
  // A two-cycle instruction can postpone entry by a whole slow instruction.
  a_latency: assert property (take && state_r == IFC_RUN && !SEQ_IN.sleep
      ##1 take[*8] |-> ##[0:8] (state_r == IFC_ENTRY || !take))
    else $error("entry not reached in time");

  a_tmr_flag: assert property (tmr_set |=> ctrl_r[IFC_B_TF])
    else $error("timer wrap did not set flag");

  a_wr_flag: assert property (EVENTS_IN.write_done |=> xflag_r[IFC_B_WF])
    else $error("write done did not set flag");

  a_chg_sticky: assert property (ctrl_r[IFC_B_CF] && !wr_ctrl |=> ctrl_r[IFC_B_CF])
    else $error("port flag cleared itself");

  a_tmr_sticky: assert property (ctrl_r[IFC_B_TF] && !wr_ctrl |=> ctrl_r[IFC_B_TF])
    else $error("timer flag cleared itself");

  a_wf_sticky: assert property (xflag_r[IFC_B_WF] && !wr_xflag |=> xflag_r[IFC_B_WF])
    else $error("write flag cleared itself");

  a_irq_level: assert property (IRQ_OUT == $past(take))
    else $error("interrupt output does not follow request");

  a_req_level: assert property (IRQ_REQ_OUT == $past(slot_pend_r))
    else $error("request output does not follow slot");

  a_push_addr: assert property (PUSH_OUT |-> PUSH_ADDR_OUT == $past(SEQ_IN.pc))
    else $error("pushed address is not the return address");

  a_entry_gated: assert property (s_entry |-> $past(ctrl_r[IFC_B_GIE], 2))
    else $error("entry without global enable");

  a_entry_once: assert property (s_entry |=> !s_entry)
    else $error("entry lasted more than one cycle");

  a_vector_const: assert property (VECTOR_ADDR_OUT == IFC_VECTOR)
    else $error("vector address wrong");

  a_asleep_out: assert property (ASLEEP_OUT == asleep)
    else $error("sleep output does not follow state");

  a_sleep_go: assert property (s_sleep_req |=> asleep)
    else $error("sleep request ignored");

  a_sleep_nop: assert property (!asleep && SEQ_IN.sleep && any_en |=> !asleep)
    else $error("slept with an enabled flag pending");

  a_wake_only_en: assert property (asleep && !wake |=> asleep)
    else $error("woke without an enabled flag");

  a_div_hold: assert property (asleep && $past(asleep) |-> div_r == 2'b00)
    else $error("cycle divider ran while asleep");

  a_pin_quiet: assert property (!pin_edge && !wr_ctrl && !ctrl_r[IFC_B_PF]
      |=> !ctrl_r[IFC_B_PF])
    else $error("pin flag set without an edge");

  a_chg_quiet: assert property (!port_chg && !wr_ctrl && !ctrl_r[IFC_B_CF]
      |=> !ctrl_r[IFC_B_CF])
    else $error("port flag set without a change");

  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready stood longer than one cycle");

  a_slverr_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error response without ready");

  a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h00000000)
    else $error("read data outside access cycle");

endmodule : ifc_top

// file: design/ifc_pkg.sv
// Purpose: Constants, register map and types of the interrupt flag controller.
// Assumes: One 125 MHz core clock; an instruction cycle is four core clocks.
// Notes:   Registers sit on APB, one aligned 32-bit word each, data in low bits.
package ifc_pkg;

  localparam int          IFC_DATA_W    = 8;
  localparam int          IFC_PC_W      = 13;
  localparam int          IFC_CYC_DIV   = 4;
  localparam logic [12:0] IFC_VECTOR    = 13'h0004;

  // Byte offsets of the APB registers.
  localparam logic [7:0] IFC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] IFC_OFS_OPTION = 8'h04;
  localparam logic [7:0] IFC_OFS_XFLAG  = 8'h08;
  localparam logic [7:0] IFC_OFS_STATE  = 8'h0C;

  // Bit positions in the control, option and extra flag registers.
  localparam int IFC_B_GIE  = 7;
  localparam int IFC_B_TIE  = 5;
  localparam int IFC_B_PIE  = 4;
  localparam int IFC_B_CIE  = 3;
  localparam int IFC_B_TF   = 2;
  localparam int IFC_B_PF   = 1;
  localparam int IFC_B_CF   = 0;
  localparam int IFC_B_EDGE = 6;
  localparam int IFC_B_WIE  = 1;
  localparam int IFC_B_WF   = 0;

  localparam logic [7:0] IFC_CTRL_RST   = 8'h00;
  localparam logic [7:0] IFC_OPTION_RST = 8'hFF;
  localparam logic [7:0] IFC_XFLAG_RST  = 8'h00;

  typedef enum logic [1:0]
  {
    IFC_RUN   = 2'b00,
    IFC_ENTRY = 2'b01,
    IFC_SLEEP = 2'b10
  } ifc_state_t;

  typedef struct packed
  {
    logic       pin;
    logic [3:0] port_hi;
    logic       timer_wrap;
    logic       write_done;
  } ifc_events_t;

  typedef struct packed
  {
    logic       return_from_irq_instr;
    logic       sleep;
    logic       cycle_done;
    logic [12:0] pc;
  } ifc_seq_t;

endpackage : ifc_pkg

// file: bench/ifc_seq_model.sv
// Purpose: Instruction sequencer model facing the interrupt flag controller.
// Assumes: An instruction lasts IFC_CYC_DIV clocks, twice that when slow_in is high.
// Notes:   No instruction ends in sleep, since the instruction count is held at zero there.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module ifc_seq_model
  import ifc_pkg::*;
#(
  parameter logic [12:0] START_PC = 13'h0ABC
)
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Bench requests
  input  wire logic        slow_in,
  input  wire logic        return_from_irq_instr_in,
  input  wire logic        sleep_in,
  // Controller side
  input  wire logic        vector_load_in,
  input  wire logic [12:0] vector_addr_in,
  input  wire logic        asleep_in,
  output ifc_seq_t         seq_out
);
  logic [3:0]  cnt_r;
  logic [12:0] pc_r;
  logic [3:0]  last_w;
  logic        done_w;

  assign last_w = slow_in ? 4'(2 * IFC_CYC_DIV - 1) : 4'(IFC_CYC_DIV - 1);
  assign done_w = rst_n_in && !asleep_in && (cnt_r == last_w);
  assign seq_out = '{return_from_irq_instr: return_from_irq_instr_in, sleep: sleep_in, cycle_done: done_w, pc: pc_r};

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || asleep_in || done_w)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
    if (!rst_n_in)
      pc_r <= START_PC;
    else if (vector_load_in)
      pc_r <= vector_addr_in;
  end
endmodule : ifc_seq_model

// file: bench/tb.sv
// Purpose: Self-checking bench of the interrupt flag controller.
// Assumes: The sequencer model ends instructions; APB waits are bounded by timeout.
// Notes:   Expected values follow the control register layout.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module tb
  import ifc_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  ifc_events_t ev;
  ifc_seq_t    seq;
  logic        irq_req, vload, push, wake, asleep, irq, slow, return_from_irq_instr, sleep_rq;
  logic [12:0] vaddr, push_addr;
  int          err_count, comparisons, cycles, n;

  always #4 clk = ~clk;

  ifc_top i_ifc_top (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EVENTS_IN(ev), .SEQ_IN(seq),
    .IRQ_REQ_OUT(irq_req), .VECTOR_LOAD_OUT(vload), .VECTOR_ADDR_OUT(vaddr),
    .PUSH_OUT(push), .PUSH_ADDR_OUT(push_addr), .WAKE_OUT(wake),
    .ASLEEP_OUT(asleep), .IRQ_OUT(irq));

  ifc_seq_model i_ifc_seq_model (
    .clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .return_from_irq_instr_in(return_from_irq_instr),
    .sleep_in(sleep_rq), .vector_load_in(vload), .vector_addr_in(vaddr),
    .asleep_in(asleep), .seq_out(seq));

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // Pin and port levels are held two instruction cycles, longer than required.
  task automatic drv(input logic p, input logic [3:0] h);
    @(posedge clk);
    ev.pin     <= p;
    ev.port_hi <= h;
    repeat (2 * IFC_CYC_DIV) @(posedge clk);
  endtask : drv

  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: ev.timer_wrap <= 1'b1;
      1: ev.write_done <= 1'b1;
      2: return_from_irq_instr <= 1'b1;
      default: sleep_rq <= 1'b1;
    endcase
    @(posedge clk);
    {ev.timer_wrap, ev.write_done, return_from_irq_instr, sleep_rq} <= 4'h0;
  endtask : pulse

  task automatic vwait();
    n = 0;
    while (vload !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
  endtask : vwait

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk, rst_n, psel, penable, pwrite, slow, return_from_irq_instr, sleep_rq} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = '{pin: 1'b1, port_hi: 4'h0, timer_wrap: 1'b0, write_done: 1'b0};
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(IFC_OFS_CTRL, 32'h00);
    rchk(IFC_OFS_OPTION, 32'hFF);
    rchk(8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    pulse(0);
    rchk(IFC_OFS_CTRL, 32'h04);
    drv(1'b1, 4'hA);
    rchk(IFC_OFS_CTRL, 32'h05);
    pulse(1);
    rchk(IFC_OFS_XFLAG, 32'h01);
    apb(1'b1, IFC_OFS_OPTION, 32'hBF);
    drv(1'b0, 4'hA);
    rchk(IFC_OFS_CTRL, 32'h07);
    apb(1'b1, IFC_OFS_CTRL, 32'h00);
    drv(1'b1, 4'hA);
    apb(1'b1, IFC_OFS_OPTION, 32'hFF);
    drv(1'b0, 4'hA);
    rchk(IFC_OFS_CTRL, 32'h00);
    drv(1'b1, 4'hA);
    rchk(IFC_OFS_CTRL, 32'h02);
    apb(1'b1, IFC_OFS_CTRL, 32'h12);
    vwait();
    chk({31'h0, vload}, 32'h0);
    chk({30'h0, irq_req, irq}, 32'h0);
    drv(1'b0, 4'hA);
    apb(1'b1, IFC_OFS_CTRL, 32'h90);
    @(posedge clk);
    ev.pin <= 1'b1;
    vwait();
    chk(32'(n <= 4 * IFC_CYC_DIV), 32'h1);
    chk({30'h0, irq_req, irq}, 32'h3);
    chk({19'h0, vaddr}, 32'h0004);
    chk({18'h0, push, push_addr}, 32'h2ABC);
    rchk(IFC_OFS_CTRL, 32'h12);
    pulse(2);
    vwait();
    chk({18'h0, vload, push_addr}, 32'h2004);
    slow <= 1'b1;
    apb(1'b1, IFC_OFS_CTRL, 32'hA0);
    pulse(0);
    vwait();
    chk({31'h0, vload}, 32'h1);
    slow <= 1'b0;
    apb(1'b1, IFC_OFS_CTRL, 32'h10);
    drv(1'b0, 4'hA);
    pulse(3);
    repeat (2) @(posedge clk);
    chk({31'h0, asleep}, 32'h1);
    pulse(0);
    @(posedge clk);
    ev.pin <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 40), 32'h1);
    vwait();
    chk({31'h0, vload}, 32'h0);
    rchk(IFC_OFS_CTRL, 32'h12);
    apb(1'b1, IFC_OFS_CTRL, 32'h90);
    drv(1'b0, 4'hA);
    pulse(3);
    repeat (2) @(posedge clk);
    ev.pin <= 1'b1;
    vwait();
    chk({31'h0, vload}, 32'h1);
    apb(1'b1, IFC_OFS_CTRL, 32'h08);
    drv(1'b0, 4'hA);
    pulse(3);
    drv(1'b1, 4'hA);
    chk({31'h0, asleep}, 32'h1);
    drv(1'b1, 4'h5);
    chk({31'h0, asleep}, 32'h0);
    tally_and_finish();
  end
endmodule : tb
